// ===== gcgr_regs.v
// Global configuration, output halt and pin function register bank.
`timescale 1ns/1ps
`include "gcgr_defines.vh"
module gcgr_regs #(
   parameter [11:0] PART_CODE = 12'h5a3, // Arbitrary neutral value.
   parameter [3:0]  REVISION  = 4'h0
) (
   input  wire        i_clk,
   input  wire        i_rst_n,
   input  wire        i_hard_reset_bit,
   input  wire        i_soft_reset_bit,
   input  wire        i_global_stop,
   input  wire        i_reg_wr,
   input  wire        i_reg_rd,
   input  wire [6:0]  i_reg_addr,
   input  wire [7:0]  i_reg_wdata,
   output reg  [7:0]  o_reg_rdata,
   input  wire [1:0]  i_if_sel_pin,
   input  wire [3:0]  i_pin_in,
   output reg  [3:0]  o_pin_out,
   output reg  [3:0]  o_pin_oe,
   input  wire [39:0] i_halt_source_field,
   output reg  [9:0]  o_halt_request,
   output reg  [1:0]  o_group_d_source_sel,
   output reg  [1:0]  o_group_e_source_sel,
   output reg  [1:0]  o_group_f_source_sel,
   input  wire        i_boot_done,
   input  wire [3:0]  i_input_isr,
   input  wire [7:0]  i_out_isr1,
   input  wire [1:0]  i_out_isr2,
   input  wire        i_loop_isr,
   output reg         o_irq_status
);

   // Pin drive for one configuration code; bit 1 is enable, bit 0 level.
   function [1:0] pin_drive;
      input [3:0] code;
      input       fbit;
      begin
         case (code)
            `GCGR_PIN_LOW:     pin_drive = 2'h2;
            `GCGR_PIN_HIGH:    pin_drive = 2'h3;
            `GCGR_PIN_ST_TRUE: pin_drive = {1'b1, fbit};
            `GCGR_PIN_ST_INV:  pin_drive = {1'b1, ~fbit};
            `GCGR_PIN_ST_OD0:  pin_drive = {~fbit, 1'b0};
            `GCGR_PIN_ST_OD1:  pin_drive = {fbit, 1'b0};
            default:           pin_drive = 2'h0;
         endcase
      end
   endfunction

   // Pin synchronisers are left out of reset so straps are valid at release.
   reg  [3:0] pin_meta;
   reg  [3:0] pin_sync;
   reg  [1:0] ifs_meta;
   reg  [1:0] ifs_sync;
   reg  [3:0] pin_prev;
   reg        released;
   reg        hard_prev;
   reg  [7:0] group_src;
   reg  [7:0] halt1;
   reg  [1:0] halt2;
   reg  [7:0] pincfg1;
   reg  [7:0] pincfg2;
   reg  [7:0] follow0;
   reg  [7:0] follow1;
   reg  [7:0] follow2;
   reg  [7:0] follow3;
   reg  [6:0] slave_addr;
   reg        configured_flag;
   reg  [1:0] interface_mode;
   reg        test_mode;
   reg  [2:0] autoconfig_select_bits;
   reg  [3:0] change_flag;
   reg  [3:0] change_irq_en;
   reg        global_irq_enable;

   wire       block_rst = ~i_rst_n | i_hard_reset_bit | i_soft_reset_bit;
   wire       cfg_rst   = ~i_rst_n | i_hard_reset_bit;
   wire       wr_hit_ok = i_reg_wr & ~block_rst;

   wire       output_irq_summary     = |{i_out_isr1, i_out_isr2};
   wire       input_irq_summary      = |i_input_isr;
   wire       synth_loop_irq_summary = i_loop_isr;
   wire       next_irq = global_irq_enable &
                         (output_irq_summary | input_irq_summary |
                          synth_loop_irq_summary |
                          (|(change_flag & change_irq_en)));

   wire [7:0] cfg_status   = {configured_flag, 1'b0, interface_mode,
                              test_mode, autoconfig_select_bits};
   wire [7:0] pin_status   = {change_flag, pin_sync};
   wire [7:0] irq_summary  = {2'h0, output_irq_summary, input_irq_summary,
                              1'b0, synth_loop_irq_summary,
                              global_irq_enable, o_irq_status};
   wire [7:0] global_isr   = {i_boot_done, 3'h0, change_irq_en};

   // Followable status space; pin status at 0x41 and every register not
   // implemented here read as zero, so a pin following them with code 0100 drives low.
   wire [255:0] follow_vec = {
      {24{8'h00}},
      {7'h00, i_loop_isr},
      {6'h00, i_out_isr2},
      i_out_isr1,
      {4'h0, i_input_isr},
      global_isr,
      irq_summary,
      8'h00,
      cfg_status};

   wire       fbit0 = follow_vec[follow0];
   wire       fbit1 = follow_vec[follow1];
   wire       fbit2 = follow_vec[follow2];
   wire       fbit3 = follow_vec[follow3];

   wire [1:0] drv0 = pin_drive(pincfg1[3:0], fbit0);
   wire [1:0] drv1 = pin_drive(pincfg1[7:4], fbit1);
   wire [1:0] drv2 = pin_drive(pincfg2[3:0], fbit2);
   wire [1:0] drv3 = pin_drive(pincfg2[7:4], fbit3);

   wire [9:0] halt_bits = {halt2, halt1};
   reg  [9:0] next_halt;
   reg  [3:0] next_change;
   reg  [7:0] next_rdata;
   integer    k;

   always @* begin
      next_halt = 10'h000;
      for (k = 0; k < 10; k = k + 1) begin
         if (i_halt_source_field[4*k +: 4] == `GCGR_HALT_BY_REG) begin
            next_halt[k] = halt_bits[k] | i_global_stop;
         end
      end
   end

   always @* begin
      next_change = change_flag;
      if (wr_hit_ok && i_reg_addr == `GCGR_A_PIN_STATUS) begin
         next_change = change_flag & ~i_reg_wdata[7:4];
      end
      next_change = next_change | (pin_sync ^ pin_prev);
   end

   always @* begin
      next_rdata = 8'h00;
      if (i_reg_addr == `GCGR_A_GROUP_SRC) begin
         next_rdata = group_src;
      end else if (i_reg_addr == `GCGR_A_HALT1) begin
         next_rdata = halt1;
      end else if (i_reg_addr == `GCGR_A_HALT2) begin
         next_rdata = {6'h00, halt2};
      end else if (i_reg_addr == `GCGR_A_PINCFG1) begin
         next_rdata = pincfg1;
      end else if (i_reg_addr == `GCGR_A_PINCFG2) begin
         next_rdata = pincfg2;
      end else if (i_reg_addr == `GCGR_A_FOLLOW0) begin
         next_rdata = follow0;
      end else if (i_reg_addr == `GCGR_A_FOLLOW1) begin
         next_rdata = follow1;
      end else if (i_reg_addr == `GCGR_A_FOLLOW2) begin
         next_rdata = follow2;
      end else if (i_reg_addr == `GCGR_A_FOLLOW3) begin
         next_rdata = follow3;
      end else if (i_reg_addr == `GCGR_A_SLAVE_ADDR) begin
         next_rdata = {1'b0, slave_addr};
      end else if (i_reg_addr == `GCGR_A_PART_HI) begin
         next_rdata = PART_CODE[11:4];
      end else if (i_reg_addr == `GCGR_A_PART_LO) begin
         next_rdata = {PART_CODE[3:0], REVISION};
      end else if (i_reg_addr[6:5] == 2'h2) begin
         next_rdata = follow_vec[8*i_reg_addr[4:0] +: 8];
         if (i_reg_addr == `GCGR_A_PIN_STATUS) begin
            next_rdata = pin_status;
         end
      end
   end

   always @(posedge i_clk) begin
      pin_meta <= i_pin_in;
      pin_sync <= pin_meta;
      ifs_meta <= i_if_sel_pin;
      ifs_sync <= ifs_meta;
      hard_prev <= i_hard_reset_bit;
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         released   <= 1'b0;
         slave_addr <= {`GCGR_SLAVE_DEF_HI, 2'h0};
      end else begin
         released <= 1'b1;
         if (!released) begin
            slave_addr[1:0] <= ifs_sync;
         end else if (i_reg_wr && i_reg_addr == `GCGR_A_SLAVE_ADDR) begin
            // Zero is never written by software, so it is not filtered.
            slave_addr <= i_reg_wdata[6:0];
         end
      end
   end

   // Straps are caught in the first cycle after the reset pin is released, and all but
   // interface mode after the hard reset bit; the soft reset bit leaves them alone.
   always @(posedge i_clk) begin
      if (cfg_rst) begin
         // Interface mode follows the reset pin alone, so a hard reset
         // bit cannot lose the host's own interface selection.
         if (!i_rst_n) begin
            interface_mode <= 2'h0;
         end
         test_mode              <= 1'b0;
         autoconfig_select_bits <= 3'h0;
      end else if (!released || hard_prev) begin
         if (!released) begin
            interface_mode <= ifs_sync;
         end
         test_mode              <= pin_sync[3];
         autoconfig_select_bits <= pin_sync[2:0];
      end
   end

   always @(posedge i_clk) begin
      if (block_rst) begin
         configured_flag <= 1'b0;
      end else if (i_reg_wr) begin
         configured_flag <= 1'b1;
      end
   end

   always @(posedge i_clk) begin
      if (block_rst) begin
         group_src         <= `GCGR_RST_BYTE;
         halt1             <= `GCGR_RST_BYTE;
         halt2             <= 2'h0;
         pincfg1           <= `GCGR_RST_BYTE;
         pincfg2           <= `GCGR_RST_BYTE;
         follow0           <= `GCGR_RST_BYTE;
         follow1           <= `GCGR_RST_BYTE;
         follow2           <= `GCGR_RST_BYTE;
         follow3           <= `GCGR_RST_BYTE;
         change_irq_en     <= 4'h0;
         global_irq_enable <= 1'b0;
         change_flag       <= 4'h0;
         pin_prev          <= pin_sync;
      end else begin
         change_flag <= next_change;
         pin_prev    <= pin_sync;
         if (wr_hit_ok) begin
            if (i_reg_addr == `GCGR_A_GROUP_SRC) begin
               group_src <= i_reg_wdata;
            end else if (i_reg_addr == `GCGR_A_HALT1) begin
               halt1 <= i_reg_wdata;
            end else if (i_reg_addr == `GCGR_A_HALT2) begin
               halt2 <= i_reg_wdata[1:0];
            end else if (i_reg_addr == `GCGR_A_PINCFG1) begin
               pincfg1 <= i_reg_wdata;
            end else if (i_reg_addr == `GCGR_A_PINCFG2) begin
               pincfg2 <= i_reg_wdata;
            end else if (i_reg_addr == `GCGR_A_FOLLOW0) begin
               follow0 <= i_reg_wdata;
            end else if (i_reg_addr == `GCGR_A_FOLLOW1) begin
               follow1 <= i_reg_wdata;
            end else if (i_reg_addr == `GCGR_A_FOLLOW2) begin
               follow2 <= i_reg_wdata;
            end else if (i_reg_addr == `GCGR_A_FOLLOW3) begin
               follow3 <= i_reg_wdata;
            end else if (i_reg_addr == `GCGR_A_IRQ_SUMMARY) begin
               global_irq_enable <= i_reg_wdata[1];
            end else if (i_reg_addr == `GCGR_A_GLOBAL_ISR) begin
               change_irq_en <= i_reg_wdata[3:0];
            end
         end
      end
   end

   // Code 10 is ignored so a stray write cannot glitch a clock group.
   always @(posedge i_clk) begin
      if (block_rst) begin
         o_group_d_source_sel <= `GCGR_SRC_INT;
         o_group_e_source_sel <= `GCGR_SRC_INT;
         o_group_f_source_sel <= `GCGR_SRC_INT;
      end else begin
         if (group_src[1:0] != `GCGR_SRC_UNUSED) begin
            o_group_d_source_sel <= group_src[1:0];
         end
         if (group_src[3:2] != `GCGR_SRC_UNUSED) begin
            o_group_e_source_sel <= group_src[3:2];
         end
         if (group_src[5:4] != `GCGR_SRC_UNUSED) begin
            o_group_f_source_sel <= group_src[5:4];
         end
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_reg_rdata    <= 8'h00;
         o_pin_out      <= 4'h0;
         o_pin_oe       <= 4'h0;
         o_halt_request <= 10'h000;
         o_irq_status   <= 1'b0;
      end else begin
         if (i_reg_rd) begin
            o_reg_rdata <= next_rdata;
         end
         o_pin_out      <= {drv3[0], drv2[0], drv1[0], drv0[0]};
         o_pin_oe       <= {drv3[1], drv2[1], drv1[1], drv0[1]};
         o_halt_request <= next_halt;
         o_irq_status   <= next_irq;
      end
   end

endmodule // gcgr_regs

// ===== gcgr_defines.vh
// Constants for the global configuration and pin register bank.
// Functional notes
// - Group source codes 00 int, 01 frac, 11 path2.
// - Output halts on own bit or global stop.
// - Pin codes select input, inverted input, low, high.
// - Status output codes 0100 to 0111 drive rules.
// - Pin state bit shows raw pin level.
// - Followed register is 0x40 plus register field.
// - Bit field picks bit 0 to 7.
// - Unimplemented followed bit drives pin low.
// - Pin status and loop enable regs not followable.
// - Reset pin loads slave address defaults and pins.
// - Read-only twelve-bit part code over two registers.
// - Low nibble holds hardware revision from zero.
// - Configured flag clears on resets, sets on write.
// - Interface mode bits capture select pins at release.
// - Test bit captures test pin at release.
// - Autoconfig bits capture three pins at release.
// - Change flag sets on edge, clears on write one.
// - Summary bits OR their interrupt status registers.
// - Global enable low blocks global status bit.
// - Change enable gates flag into interrupt logic.
`ifndef GCGR_DEFINES_VH
`define GCGR_DEFINES_VH
`define GCGR_A_GROUP_SRC   7'h08
`define GCGR_A_HALT1       7'h09
`define GCGR_A_HALT2       7'h0a
`define GCGR_A_PINCFG1     7'h0b
`define GCGR_A_PINCFG2     7'h0c
`define GCGR_A_FOLLOW0     7'h0d
`define GCGR_A_FOLLOW1     7'h0e
`define GCGR_A_FOLLOW2     7'h0f
`define GCGR_A_FOLLOW3     7'h10
`define GCGR_A_SLAVE_ADDR  7'h11
`define GCGR_A_PART_HI     7'h30
`define GCGR_A_PART_LO     7'h31
`define GCGR_A_CFG_STATUS  7'h40
`define GCGR_A_PIN_STATUS  7'h41
`define GCGR_A_IRQ_SUMMARY 7'h42
`define GCGR_A_GLOBAL_ISR  7'h43
`define GCGR_A_INPUT_ISR   7'h44
`define GCGR_A_OUT_ISR1    7'h45
`define GCGR_A_OUT_ISR2    7'h46
`define GCGR_A_LOOP_ISR    7'h47
`define GCGR_STATUS_BASE   7'h40
`define GCGR_SRC_INT       2'h0
`define GCGR_SRC_FRAC      2'h1
`define GCGR_SRC_UNUSED    2'h2
`define GCGR_SRC_PATH2     2'h3
`define GCGR_HALT_BY_REG   4'h1
`define GCGR_PIN_IN        4'h0
`define GCGR_PIN_IN_INV    4'h1
`define GCGR_PIN_LOW       4'h2
`define GCGR_PIN_HIGH      4'h3
`define GCGR_PIN_ST_TRUE   4'h4
`define GCGR_PIN_ST_INV    4'h5
`define GCGR_PIN_ST_OD0    4'h6
`define GCGR_PIN_ST_OD1    4'h7
`define GCGR_SLAVE_DEF_HI  5'h1b
`define GCGR_RST_BYTE      8'h00
`endif

// ===== gcgr_regs_asserts.sv
// Port-level checks for the configuration register bank.
`timescale 1ns/1ps
module gcgr_regs_asserts #(
   parameter [11:0] PART_CODE = 12'h5a3, // Arbitrary neutral value.
   parameter [3:0]  REVISION  = 4'h0
) (
   input wire        i_clk,
   input wire        i_rst_n,
   input wire        i_hard_reset_bit,
   input wire        i_soft_reset_bit,
   input wire        i_global_stop,
   input wire        i_reg_wr,
   input wire        i_reg_rd,
   input wire [6:0]  i_reg_addr,
   input wire [7:0]  i_reg_wdata,
   input wire [7:0]  o_reg_rdata,
   input wire [3:0]  o_pin_out,
   input wire [3:0]  o_pin_oe,
   input wire [39:0] i_halt_source_field,
   input wire [9:0]  o_halt_request,
   input wire [1:0]  o_group_d_source_sel,
   input wire        o_irq_status
);
   // Shadow of the global enable; every reset kind clears it.
   reg  ien;
   wire any_rst = !i_rst_n || i_hard_reset_bit || i_soft_reset_bit;
   always @(posedge i_clk) begin
      if (any_rst)
         ien <= 1'b0;
      else if (i_reg_wr && i_reg_addr == 7'h42)
         ien <= i_reg_wdata[1];
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (any_rst);
   sequence s_grp_wr;
      i_reg_wr && i_reg_addr == 7'h08;
   endsequence
   sequence s_pin_wr;
      i_reg_wr && i_reg_addr == 7'h0b;
   endsequence
   src_update_a: assert property (
      (s_grp_wr ##0 i_reg_wdata[1:0] != 2'h2) |->
      ##2 o_group_d_source_sel == $past(i_reg_wdata[1:0], 2))
      else $error("group d select missed write");
   src_keep_a: assert property (
      (s_grp_wr ##0 i_reg_wdata[1:0] == 2'h2) |->
      ##2 $stable(o_group_d_source_sel))
      else $error("unused group code changed select");
   pin_high_a: assert property (
      (s_pin_wr ##0 i_reg_wdata[3:0] == 4'h3) |->
      ##2 (o_pin_oe[0] && o_pin_out[0]))
      else $error("pin0 not driven high");
   halt_on_a: assert property (
      (i_global_stop && i_halt_source_field[3:0] == 4'h1) [*3]
      |-> o_halt_request[0])
      else $error("global stop did not halt output0");
   halt_off_a: assert property (
      (i_halt_source_field[39:36] != 4'h1) [*3] |-> !o_halt_request[9])
      else $error("output9 halted with other source");
   irq_block_a: assert property (
      !ien [*3] |-> !o_irq_status)
      else $error("irq status set while disabled");
   part_read_a: assert property (
      i_reg_rd && i_reg_addr == 7'h30 |=> o_reg_rdata == PART_CODE[11:4])
      else $error("part code high wrong");
   rev_read_a: assert property (
      i_reg_rd && i_reg_addr == 7'h31 |=>
      o_reg_rdata == {PART_CODE[3:0], REVISION})
      else $error("part code low or revision wrong");
endmodule // gcgr_regs_asserts

bind gcgr_regs gcgr_regs_asserts #(.PART_CODE(PART_CODE),
   .REVISION(REVISION)) u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_hard_reset_bit(i_hard_reset_bit), .i_soft_reset_bit(i_soft_reset_bit),
   .i_global_stop(i_global_stop), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
   .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
   .o_reg_rdata(o_reg_rdata), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
   .i_halt_source_field(i_halt_source_field),
   .o_halt_request(o_halt_request),
   .o_group_d_source_sel(o_group_d_source_sel),
   .o_irq_status(o_irq_status));

// ===== gcgr_host.sv
// Host processor model issuing register strobes.
`timescale 1ns/1ps
module gcgr_host (
   input  wire       i_clk,
   input  wire [7:0] i_rdata,
   output reg        o_wr,
   output reg        o_rd,
   output reg  [6:0] o_addr,
   output reg  [7:0] o_wdata
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 7'h00;
      o_wdata = 8'h00;
   end
   task wr(input [6:0] a, input [7:0] d);
      // Zero is not a legal slave address, so it is never sent.
      if (a == 7'h11 && d == 8'h00) d = 8'h01;
      @(posedge i_clk);
      #1;
      o_wr = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(posedge i_clk);
      #1;
      o_wr = 1'b0;
      o_wdata = ~d;
   endtask
   task rd(input [6:0] a, output [7:0] d);
      @(posedge i_clk);
      #1;
      o_rd = 1'b1;
      o_addr = a;
      @(posedge i_clk);
      #1;
      o_rd = 1'b0;
      d = i_rdata;
   endtask
endmodule // gcgr_host

// ===== gcgr_regs_tb.sv
// Self-checking bench for the configuration register bank.
`timescale 1ns/1ps
module gcgr_regs_tb;
   localparam [11:0] PC = 12'hc69; // Arbitrary part code.
   localparam [3:0]  RV = 4'h2;
   reg         clk = 1'b0;
   reg         rst_n = 1'b0;
   reg         soft_reset_bit = 1'b0;
   reg         hard_reset_bit = 1'b0;
   reg         gstop = 1'b0;
   reg         boot = 1'b0;
   reg  [3:0]  ext = 4'h5;
   reg  [3:0]  iisr = 4'h0;
   reg  [7:0]  oisr1 = 8'h00;
   reg  [39:0] hsrc = {4'h0, {9{4'h1}}};
   integer     num_errors = 0;
   integer     total_checks = 0;
   integer     cycles = 0;
   integer     i;
   integer     b;
   reg  [7:0]  v;
   reg  [1:0]  e;
   wire        wr, rd, irq;
   wire [6:0]  addr;
   wire [7:0]  wdata, rdata;
   wire [3:0]  pout, poe;
   wire [9:0]  halt;
   wire [5:0]  src;
   wire [3:0]  pin = (poe & pout) | (~poe & ext);
   always #12.5 clk = ~clk;
   gcgr_regs #(.PART_CODE(PC), .REVISION(RV)) u_dut (
      .i_clk(clk), .i_rst_n(rst_n), .i_hard_reset_bit(hard_reset_bit),
      .i_soft_reset_bit(soft_reset_bit), .i_global_stop(gstop), .i_reg_wr(wr),
      .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .o_reg_rdata(rdata), .i_if_sel_pin(2'b10), .i_pin_in(pin),
      .o_pin_out(pout), .o_pin_oe(poe), .i_halt_source_field(hsrc),
      .o_halt_request(halt), .o_group_d_source_sel(src[1:0]),
      .o_group_e_source_sel(src[3:2]), .o_group_f_source_sel(src[5:4]),
      .i_boot_done(boot), .i_input_isr(iisr), .i_out_isr1(oisr1),
      .i_out_isr2(2'h0), .i_loop_isr(1'b0), .o_irq_status(irq));
   gcgr_host u_host (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
      .o_addr(addr), .o_wdata(wdata));
   task chk(input string nm, input [9:0] got, input [9:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task rchk(input [6:0] a, input [7:0] exp);
      u_host.rd(a, v);
      chk($sformatf("reg %h", a), {2'b00, v}, {2'b00, exp});
   endtask
   task step(input integer n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         num_errors = num_errors + 1;
         give_verdict;
      end
   end
   task t_straps;
      rchk(7'h40, 8'h25);
      rchk(7'h11, 8'h6e);
      u_host.wr(7'h11, 8'h4c);
      rchk(7'h40, 8'ha5);
      soft_reset_bit = 1'b1;
      step(2);
      soft_reset_bit = 1'b0;
      step(1);
      rchk(7'h40, 8'h25);
      rchk(7'h11, 8'h4c);
      rchk(7'h30, PC[11:4]);
      u_host.wr(7'h30, 8'hff);
      rchk(7'h30, PC[11:4]);
      rchk(7'h31, {PC[3:0], RV});
   endtask
   task t_paths;
      for (i = 0; i < 4; i = i + 1) begin
         u_host.wr(7'h08, {2'b00, {3{i[1:0]}}});
         step(1);
         chk("src", src, (i == 2) ? 10'h015 : {3{i[1:0]}});
      end
      u_host.wr(7'h09, 8'ha5);
      u_host.wr(7'h0a, 8'h03);
      step(1);
      chk("halt", halt, 10'h1a5);
      gstop = 1'b1;
      step(3);
      chk("halt", halt, 10'h1ff);
      gstop = 1'b0;
   endtask
   task t_pins;
      for (i = 0; i < 5; i = i + 1) begin
         u_host.wr(7'h0b, (i == 4) ? 8'h08 : i[7:0]);
         step(1);
         e = (i == 2) ? 2'b10 : (i == 3) ? 2'b11 : 2'b00;
         chk("pin0", {poe[0], poe[0] & pout[0]}, e);
      end
      u_host.wr(7'h0d, 8'h1f);
      for (i = 4; i < 8; i = i + 1)
         for (b = 0; b < 2; b = b + 1) begin
            boot = b[0];
            u_host.wr(7'h0b, i[7:0]);
            step(2);
            e = (i == 4) ? {1'b1, b[0]} : (i == 5) ? {1'b1, ~b[0]} :
               (i == 6) ? {~b[0], 1'b0} : {b[0], 1'b0};
            chk("follow", {poe[0], poe[0] & pout[0]}, e);
         end
      ext[1] = 1'b1;
      u_host.wr(7'h0d, 8'h09);
      u_host.wr(7'h0b, 8'h04);
      step(2);
      chk("nofollow", {poe[0], pout[0]}, 2'b10);
      u_host.wr(7'h0d, 8'h06);
      step(2);
      chk("nofollow", {poe[0], pout[0]}, 2'b10);
      u_host.wr(7'h0b, 8'h10);
      ext[1] = 1'b0;
      step(4);
      u_host.rd(7'h41, v);
      chk("state", v[3:0], 4'h5);
   endtask
   task t_events;
      u_host.wr(7'h41, 8'hf0);
      ext[2] = 1'b0;
      step(5);
      u_host.rd(7'h41, v);
      chk("flags", v[7:4], 4'h4);
      u_host.wr(7'h42, 8'h02);
      u_host.wr(7'h43, 8'h04);
      step(3);
      chk("irq", irq, 10'h001);
      u_host.wr(7'h43, 8'h00);
      step(3);
      chk("irq", irq, 10'h000);
      u_host.wr(7'h43, 8'h04);
      u_host.wr(7'h42, 8'h00);
      step(3);
      chk("irq", irq, 10'h000);
      u_host.wr(7'h41, 8'h40);
      rchk(7'h41, 8'h01);
      oisr1 = 8'h10;
      iisr = 4'h2;
      u_host.wr(7'h42, 8'h02);
      step(3);
      rchk(7'h42, 8'h33);
      oisr1 = 8'h00;
      iisr = 4'h0;
      step(3);
      rchk(7'h42, 8'h02);
   endtask
   // The pin edge reaches the flag logic in the very cycle the clear lands.
   task t_hard;
      ext[3] = 1'b1;
      step(1);
      u_host.wr(7'h41, 8'h80);
      rchk(7'h41, 8'h89);
      hard_reset_bit = 1'b1;
      step(2);
      hard_reset_bit = 1'b0;
      step(1);
      rchk(7'h40, 8'h29);
      rchk(7'h11, 8'h4c);
   endtask
   initial begin
      step(3);
      rst_n = 1'b1;
      t_straps;
      $display("straps and identity test done");
      t_paths;
      $display("source and halt test done");
      t_pins;
      $display("pin function test done");
      t_events;
      $display("change and interrupt test done");
      t_hard;
      $display("hard reset and clear race test done");
      give_verdict;
   end
endmodule // gcgr_regs_tb
